// File: logic/llpwc_pkg.sv
// Package: mode states, wake sources and filter timing for the mode controller
package llpwc_pkg;

    // Operating modes
    typedef enum logic [2:0] {
        LLPWC_STANDBY,
        LLPWC_NORMAL,
        LLPWC_STOP,
        LLPWC_SLEEP
    } llpwc_mode_t;

    // Wake source shown in standby
    typedef enum logic [1:0] {
        LLPWC_SRC_POWERUP,
        LLPWC_SRC_BUS,
        LLPWC_SRC_LOCAL,
        LLPWC_SRC_NONE
    } llpwc_src_t;

    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TB_DIV = 250;
    localparam logic [7:0] TB_DIV_LAST = 8'(TB_DIV - 1);

    // Times in microseconds, filters counted in 1 us ticks
    localparam int unsigned MODE_FILT_MIN_US = 50;
    localparam int unsigned MODE_FILT_MAX_US = 150;
    localparam int unsigned WAKE_FILT_MIN_US = 30;
    localparam int unsigned WAKE_FILT_MAX_US = 150;
    localparam int unsigned BUS_FILT_US = 150;
    localparam int unsigned TICK_US = TB_DIV / CLK_MHZ;

    localparam int unsigned MODE_FILT_TICKS =
        (MODE_FILT_MIN_US + MODE_FILT_MAX_US) / 2 / TICK_US;
    localparam int unsigned WAKE_FILT_TICKS =
        (WAKE_FILT_MIN_US + WAKE_FILT_MAX_US) / 2 / TICK_US;
    localparam int unsigned BUS_FILT_TICKS = BUS_FILT_US / TICK_US;

    localparam int unsigned FILT_W = 8;
    localparam logic [FILT_W-1:0] MODE_FILT_CNT = FILT_W'(MODE_FILT_TICKS);
    localparam logic [FILT_W-1:0] WAKE_FILT_CNT = FILT_W'(WAKE_FILT_TICKS);
    localparam logic [FILT_W-1:0] BUS_FILT_CNT = FILT_W'(BUS_FILT_TICKS);

endpackage : llpwc_pkg

// File: logic/llpwc_filt_if.sv
// Interface: filter tick plus qualified levels between the controller parts
interface llpwc_filt_if;
    logic tick;
    logic [3:0] level;
    logic [3:0] armed;
    logic [3:0] qual;

    modport ctrl (
        output tick,
        output level,
        output armed,
        input qual
    );

    modport filt (
        input tick,
        input level,
        input armed,
        output qual
    );
endinterface : llpwc_filt_if

// File: logic/llpwc_filter_bank.sv
// Four level filters on a shared 1 us time base
module llpwc_filter_bank (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Filter channels
    llpwc_filt_if.filt f
);

    localparam logic [llpwc_pkg::FILT_W-1:0] LIMITS [4] = '{
        llpwc_pkg::MODE_FILT_CNT,
        llpwc_pkg::MODE_FILT_CNT,
        llpwc_pkg::WAKE_FILT_CNT,
        llpwc_pkg::BUS_FILT_CNT
    };

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_ch
            logic [llpwc_pkg::FILT_W-1:0] cnt_reg;
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    cnt_reg <= '0;
                else if (!f.level[g] || !f.armed[g])
                    cnt_reg <= '0;
                else if (f.tick && cnt_reg != LIMITS[g])
                    cnt_reg <= cnt_reg + 1'b1;
            end
            // Qualified on the tick at which the count reaches the filter time
            assign f.qual[g] = f.level[g] && f.armed[g]
                && (cnt_reg == LIMITS[g]);
        end
    endgenerate

endmodule : llpwc_filter_bank

// File: logic/llpwc_ctrl.sv
// Mode controller of a bus transceiver with integrated regulator
module llpwc_ctrl (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Host side pins
    input wire logic mode_sel_i,
    input wire logic mode_sel_pd_i,
    input wire logic txd_i,
    output logic txd_o,
    output logic txd_oe_o,
    output logic rxd_o,
    output logic rxd_oe_o,
    // Bus side: bus_i high is recessive
    input wire logic bus_i,
    input wire logic local_wake_input_i,
    output logic bus_drv_dom_o,
    output logic bus_term_en_o,
    output logic bus_rx_en_o,
    output logic bus_wake_det_en_o,
    // Supply and thermal
    input wire logic drv_hot_i,
    input wire logic reg_hot_i,
    output logic regulated_supply_output_en_o,
    // Status
    output logic [2:0] mode_o
);

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for all pins and sensors
    logic [6:0] s1_reg;
    logic [6:0] s2_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            // Idle pin levels, so no false edge follows reset
            s1_reg <= 7'h1d;
            s2_reg <= 7'h1d;
        end
        else
        begin
            s1_reg <= {reg_hot_i, drv_hot_i, local_wake_input_i,
                bus_i, txd_i, mode_sel_i, !mode_sel_pd_i};
            s2_reg <= s1_reg;
        end
    end

    logic sel;
    assign sel = s2_reg[1] && s2_reg[0];
    logic tx;
    assign tx = s2_reg[2];
    logic bus;
    assign bus = s2_reg[3];
    logic wk;
    assign wk = s2_reg[4];
    logic drv_hot;
    assign drv_hot = s2_reg[5];
    logic reg_hot;
    assign reg_hot = s2_reg[6];

    ////////////////////////////////////////////////////////////////////////
    // 1 us time base
    logic [7:0] div_reg;
    logic tick_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_reg <= 8'h00;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= (div_reg == llpwc_pkg::TB_DIV_LAST);
            if (div_reg == llpwc_pkg::TB_DIV_LAST)
                div_reg <= 8'h00;
            else
                div_reg <= div_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    llpwc_pkg::llpwc_mode_t mode_reg;
    llpwc_pkg::llpwc_src_t src_reg;
    logic bus_prev_reg;
    logic wk_prev_reg;
    logic bus_arm_reg;
    logic wk_arm_reg;
    logic bus_pend_reg;
    logic low_pwr;
    assign low_pwr = (mode_reg == llpwc_pkg::LLPWC_STOP)
        || (mode_reg == llpwc_pkg::LLPWC_SLEEP);

    llpwc_filt_if fi ();
    assign fi.tick = tick_reg;
    // Channels: 0 select high, 1 transmit level, 2 local wake low, 3 bus dom
    assign fi.level[0] = sel;
    assign fi.level[1] = tx;
    assign fi.level[2] = !wk;
    assign fi.level[3] = !bus;
    assign fi.armed[0] = low_pwr || (mode_reg == llpwc_pkg::LLPWC_STANDBY);
    // Stop only; normal exit times tx from select low
    assign fi.armed[1] = (mode_reg == llpwc_pkg::LLPWC_STOP);
    assign fi.armed[2] = wk_arm_reg;
    assign fi.armed[3] = bus_arm_reg;

    llpwc_filter_bank u_filt (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .f(fi)
    );

    // Transmit-level filter in normal watches select low, then tx level
    logic tx_low_run_reg;
    logic [7:0] tx_cnt_reg;
    logic tx_level_hi;
    assign tx_level_hi = tx;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bus_prev_reg <= 1'b1;
            wk_prev_reg <= 1'b1;
        end
        else
        begin
            bus_prev_reg <= bus;
            wk_prev_reg <= wk;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            bus_arm_reg <= 1'b0;
        else if (!low_pwr || bus)
            bus_arm_reg <= 1'b0;
        else if (bus_prev_reg && !bus)
            bus_arm_reg <= 1'b1;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            wk_arm_reg <= 1'b0;
        else if (!low_pwr || wk)
            wk_arm_reg <= 1'b0;
        else if (wk_prev_reg && !wk)
            wk_arm_reg <= 1'b1;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            bus_pend_reg <= 1'b0;
        else if (!low_pwr)
            bus_pend_reg <= 1'b0;
        else if (fi.qual[3])
            bus_pend_reg <= 1'b1;
    end

    // Normal-mode exit: select low latched, then tx level filtered
    logic sel_low_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            sel_low_reg <= 1'b0;
        else if (mode_reg != llpwc_pkg::LLPWC_NORMAL || sel)
            sel_low_reg <= 1'b0;
        else
            sel_low_reg <= 1'b1;
    end

    // Tx level timing after select went low
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_low_run_reg <= 1'b0;
            tx_cnt_reg <= 8'h00;
        end
        else if (!sel_low_reg || tx_level_hi != tx_low_run_reg)
        begin
            tx_low_run_reg <= tx_level_hi;
            tx_cnt_reg <= 8'h00;
        end
        else if (tick_reg && tx_cnt_reg != llpwc_pkg::MODE_FILT_CNT)
            tx_cnt_reg <= tx_cnt_reg + 8'h01;
    end
    logic tx_done;
    assign tx_done = sel_low_reg && !sel
        && (tx_cnt_reg == llpwc_pkg::MODE_FILT_CNT)
        && (tx_low_run_reg == tx_level_hi);

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer; temperature inputs deliberately not read here
    // no thermal mode change
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_reg <= llpwc_pkg::LLPWC_STANDBY;
            src_reg <= llpwc_pkg::LLPWC_SRC_POWERUP;
        end
        else
        begin
            unique case (mode_reg)
                llpwc_pkg::LLPWC_STANDBY:
                begin
                    if (fi.qual[0])
                        mode_reg <= llpwc_pkg::LLPWC_NORMAL;
                end
                llpwc_pkg::LLPWC_NORMAL:
                begin
                    if (tx_done && !tx_low_run_reg)
                        mode_reg <= llpwc_pkg::LLPWC_STOP;
                    else if (tx_done && tx_low_run_reg)
                        mode_reg <= llpwc_pkg::LLPWC_SLEEP;
                end
                llpwc_pkg::LLPWC_STOP, llpwc_pkg::LLPWC_SLEEP:
                begin
                    if (fi.qual[0])
                    begin
                        mode_reg <= llpwc_pkg::LLPWC_NORMAL;
                        src_reg <= llpwc_pkg::LLPWC_SRC_NONE;
                    end
                    else if (bus_pend_reg && bus && !bus_prev_reg)
                    begin
                        mode_reg <= llpwc_pkg::LLPWC_STANDBY;
                        src_reg <= llpwc_pkg::LLPWC_SRC_BUS;
                    end
                    else if (fi.qual[2])
                    begin
                        mode_reg <= llpwc_pkg::LLPWC_STANDBY;
                        src_reg <= llpwc_pkg::LLPWC_SRC_LOCAL;
                    end
                    else if (mode_reg == llpwc_pkg::LLPWC_STOP
                        && fi.qual[1])
                        mode_reg <= llpwc_pkg::LLPWC_SLEEP;
                end
                default:
                    mode_reg <= llpwc_pkg::LLPWC_STANDBY;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pin outputs
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            txd_o <= 1'b0;
            txd_oe_o <= 1'b0;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
            bus_drv_dom_o <= 1'b0;
            bus_term_en_o <= 1'b0;
            bus_rx_en_o <= 1'b0;
            bus_wake_det_en_o <= 1'b0;
            regulated_supply_output_en_o <= 1'b0;
            mode_o <= 3'h0;
        end
        else
        begin
            mode_o <= mode_reg;
            bus_drv_dom_o <= (mode_reg == llpwc_pkg::LLPWC_NORMAL)
                && !tx && !drv_hot && !sel_low_reg;
            bus_rx_en_o <= (mode_reg == llpwc_pkg::LLPWC_NORMAL);
            bus_wake_det_en_o <= low_pwr;
            bus_term_en_o <= !low_pwr;
            regulated_supply_output_en_o <=
                (mode_reg != llpwc_pkg::LLPWC_SLEEP) && !reg_hot;
            rxd_oe_o <= (mode_reg == llpwc_pkg::LLPWC_NORMAL)
                || (mode_reg == llpwc_pkg::LLPWC_STANDBY);
            txd_oe_o <= (mode_reg == llpwc_pkg::LLPWC_STANDBY);
            if (mode_reg == llpwc_pkg::LLPWC_NORMAL)
            begin
                rxd_o <= bus;
                txd_o <= 1'b0;
            end
            else
            begin
                unique case (src_reg)
                    llpwc_pkg::LLPWC_SRC_BUS:
                    begin
                        rxd_o <= 1'b0;
                        txd_o <= 1'b1;
                    end
                    llpwc_pkg::LLPWC_SRC_LOCAL:
                    begin
                        rxd_o <= 1'b0;
                        txd_o <= 1'b0;
                    end
                    default:
                    begin
                        rxd_o <= 1'b1;
                        txd_o <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule : llpwc_ctrl

// File: verif/llpwc_ctrl_properties.sv
// Checker: port properties of the mode controller
module llpwc_ctrl_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Host side
    input wire logic mode_sel_i,
    input wire logic mode_sel_pd_i,
    input wire logic txd_i,
    input wire logic txd_o,
    input wire logic txd_oe_o,
    input wire logic rxd_o,
    input wire logic rxd_oe_o,
    // Bus side
    input wire logic bus_drv_dom_o,
    input wire logic bus_term_en_o,
    input wire logic bus_rx_en_o,
    input wire logic bus_wake_det_en_o,
    // Supply, thermal, status
    input wire logic drv_hot_i,
    input wire logic reg_hot_i,
    input wire logic regulated_supply_output_en_o,
    input wire logic [2:0] mode_o
);
    localparam logic [2:0] M_NORM = llpwc_pkg::LLPWC_NORMAL;
    localparam logic [2:0] M_STOP = llpwc_pkg::LLPWC_STOP;
    localparam logic [2:0] M_SLP = llpwc_pkg::LLPWC_SLEEP;
    logic lp;
    logic [15:0] sel_cnt;
    logic [15:0] txl_cnt;
    assign lp = (mode_o == M_STOP) || (mode_o == M_SLP);
    ////////////////////////////////////////////////////////////
    // Select high run, pull-down counts as low
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            sel_cnt <= 16'h0;
        else if (!mode_sel_i || mode_sel_pd_i)
            sel_cnt <= 16'h0;
        else if (sel_cnt != 16'hffff)
            sel_cnt <= sel_cnt + 16'h1;
    end
    // Transmit low run while select low
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            txl_cnt <= 16'h0;
        else if (txd_i || (mode_sel_i && !mode_sel_pd_i))
            txl_cnt <= 16'h0;
        else if (txl_cnt != 16'hffff)
            txl_cnt <= txl_cnt + 16'h1;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    chk_lp_drv_off: assert property (lp [*2] |-> !bus_drv_dom_o)
        else $error("driver on in low power");
    chk_lp_rx_off: assert property (lp [*2] |->
        !bus_rx_en_o && bus_wake_det_en_o)
        else $error("receiver setup wrong in low power");
    chk_lp_term_off: assert property (lp [*2] |-> !bus_term_en_o)
        else $error("termination on in low power");
    chk_lp_pins_off: assert property (lp [*2] |->
        !rxd_oe_o && !txd_oe_o)
        else $error("host pins driven in low power");
    chk_stop_supply_on: assert property (
        (mode_o == M_STOP && !reg_hot_i) [*6] |->
        regulated_supply_output_en_o)
        else $error("supply off in stop");
    chk_reg_hot_off: assert property (
        reg_hot_i [*6] |-> !regulated_supply_output_en_o)
        else $error("supply on while regulator hot");
    chk_drv_hot_off: assert property (
        drv_hot_i [*6] |-> !bus_drv_dom_o)
        else $error("driver on while driver hot");
    chk_powerup_ind: assert property ($fell(rst_i) |=>
        rxd_oe_o && rxd_o && txd_oe_o && !txd_o)
        else $error("power-up indication wrong");
    chk_sel_filt_min: assert property (
        mode_o == M_NORM && !$stable(mode_o) |-> sel_cnt >= 16'h30d4)
        else $error("normal entered before filter time");
    chk_sel_filt_max: assert property (
        sel_cnt == 16'h9376 |-> mode_o == M_NORM)
        else $error("select high too long without normal");
    chk_stop_from_norm: assert property (
        mode_o == M_STOP && $past(mode_o) != M_STOP |->
        $past(mode_o) == M_NORM && txl_cnt >= 16'h30d4)
        else $error("bad stop entry");
endmodule // llpwc_ctrl_chk

bind llpwc_ctrl llpwc_ctrl_chk llpwc_ctrl_chk_i (.sys_clk_i, .rst_i,
    .mode_sel_i, .mode_sel_pd_i, .txd_i, .txd_o, .txd_oe_o, .rxd_o,
    .rxd_oe_o, .bus_drv_dom_o, .bus_term_en_o, .bus_rx_en_o,
    .bus_wake_det_en_o, .drv_hot_i, .reg_hot_i,
    .regulated_supply_output_en_o, .mode_o);

// File: verif/llpwc_host_model.sv
// Host model: drives the mode-select and transmit pins
module llpwc_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Pins
    output logic mode_sel_o,
    output logic txd_o,
    output logic txd_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        mode_sel_o = 1'b0;
        txd_o = 1'b1;
        txd_en_o = 1'b0;
    end
    task automatic pins(input logic sel, input logic txd, input logic en);
    begin
        @(negedge sys_clk_i);
        mode_sel_o = sel;
        txd_o = txd;
        txd_en_o = en;
    end
    endtask
endmodule // llpwc_host_model

// File: verif/testbench.sv
// Testbench: mode controller scenarios against the host model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] M_STBY = llpwc_pkg::LLPWC_STANDBY;
    localparam logic [2:0] M_NORM = llpwc_pkg::LLPWC_NORMAL;
    localparam logic [2:0] M_STOP = llpwc_pkg::LLPWC_STOP;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pd = 1'b0;
    logic far_bus = 1'b1;
    logic drv_hot = 1'b0;
    logic reg_hot = 1'b0;
    logic sel, h_txd, h_en, txd_pin, bus_pin;
    logic txd_o, txd_oe_o, rxd_o, rxd_oe_o, bus_drv_dom_o, bus_term_en_o;
    logic bus_rx_en_o, bus_wake_det_en_o, sup_en;
    logic [2:0] mode_o;
    int n_errors = 0;
    int total_checks = 0;
    int n;
    // local wake idles at battery level
    logic wk = 1'b1;
    // Transmit pin: device wins, then host driver when enabled, pull-up otherwise
    assign txd_pin = txd_oe_o ? txd_o : (h_en ? h_txd : 1'b1);
    // Bus is wired-and of far side and our driver
    assign bus_pin = far_bus & !bus_drv_dom_o;
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////
    llpwc_host_model llpwc_host_model_i (.sys_clk_i(clk),
        .mode_sel_o(sel), .txd_o(h_txd), .txd_en_o(h_en));
    llpwc_ctrl llpwc_ctrl_i (.sys_clk_i(clk), .rst_i(rst),
        .mode_sel_i(sel), .mode_sel_pd_i(pd), .txd_i(txd_pin),
        .txd_o(txd_o), .txd_oe_o(txd_oe_o), .rxd_o(rxd_o),
        .rxd_oe_o(rxd_oe_o), .bus_i(bus_pin), .local_wake_input_i(wk),
        .bus_drv_dom_o(bus_drv_dom_o), .bus_term_en_o(bus_term_en_o),
        .bus_rx_en_o(bus_rx_en_o), .bus_wake_det_en_o(bus_wake_det_en_o),
        .drv_hot_i(drv_hot), .reg_hot_i(reg_hot),
        .regulated_supply_output_en_o(sup_en), .mode_o(mode_o));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
    begin
        total_checks++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    end
    endtask
    task automatic idle(input int c);
    begin
        repeat (c) @(negedge clk);
    end
    endtask
    // Bounded wait, cycles counted into n
    task automatic wait_mode(input logic [2:0] m, input int lim);
    begin
        n = 0;
        while (mode_o !== m && n < lim)
        begin
            @(negedge clk);
            n++;
        end
    end
    endtask
    task automatic results;
    begin
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_powerup;
    begin
        chk(mode_o === M_STBY && rxd_oe_o === 1'b1
            && rxd_o === 1'b1, "rxd up");
        chk(txd_oe_o === 1'b1 && txd_o === 1'b0, "txd up");
        chk(bus_term_en_o === 1'b1 && sup_en === 1'b1, "standby");
    end
    endtask
    // Select high; thermal events while in normal
    task automatic t_normal;
    begin
        llpwc_host_model_i.pins(1'b1, 1'b0, 1'b1);
        wait_mode(M_NORM, 40000);
        chk(n > 12500 && n < 37500, "normal timing");
        drv_hot = 1'b1;
        idle(20);
        chk(bus_drv_dom_o === 1'b0 && bus_rx_en_o === 1'b1
            && rxd_o === 1'b1, "drv hot");
        chk(mode_o === M_NORM, "hot changed mode");
        drv_hot = 1'b0;
        idle(20);
        chk(bus_drv_dom_o === 1'b1 && rxd_o === 1'b0, "driver back");
        reg_hot = 1'b1;
        idle(20);
        chk(sup_en === 1'b0, "reg hot");
        reg_hot = 1'b0;
        idle(20);
        chk(sup_en === 1'b1, "supply back");
        llpwc_host_model_i.pins(1'b1, 1'b1, 1'b1);
        // Select still high, tx high must not leave normal
        idle(200);
        chk(mode_o === M_NORM, "normal held");
    end
    endtask
    task automatic t_stop;
    begin
        llpwc_host_model_i.pins(1'b0, 1'b0, 1'b1);
        wait_mode(M_STOP, 40000);
        chk(n > 12500 && n < 37500, "stop timing");
        idle(2);
        chk(bus_drv_dom_o === 1'b0
            && bus_rx_en_o === 1'b0, "stop drv");
        chk(bus_wake_det_en_o === 1'b1, "wake det");
        chk(bus_term_en_o === 1'b0 && sup_en === 1'b1, "stop term");
        chk(rxd_oe_o === 1'b0 && txd_oe_o === 1'b0, "stop pins");
    end
    endtask
    // Short local pulse, floating select, then bus wake
    task automatic t_wake;
    begin
        wk = 1'b0;
        idle(2500);
        wk = 1'b1;
        idle(500);
        chk(mode_o === M_STOP, "short pulse woke");
        pd = 1'b1;
        llpwc_host_model_i.pins(1'b1, 1'b0, 1'b1);
        far_bus = 1'b0;
        idle(38000);
        chk(mode_o === M_STOP, "early wake");
        llpwc_host_model_i.pins(1'b0, 1'b0, 1'b1);
        pd = 1'b0;
        far_bus = 1'b1;
        wait_mode(M_STBY, 1000);
        chk(n < 1000, "bus wake");
        llpwc_host_model_i.pins(1'b0, 1'b0, 1'b0);
        idle(2);
        chk(rxd_oe_o === 1'b1 && rxd_o === 1'b0, "wake rxd");
        chk(txd_oe_o === 1'b1 && txd_o === 1'b1, "wake txd");
    end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        idle(20);
        rst = 1'b0;
        idle(2);
        t_powerup();
        t_normal();
        t_stop();
        t_wake();
        results();
    end
    // Run needs about 370 us
    initial
    begin
        #440000;
        n_errors++;
        results();
    end
endmodule // testbench
